//--- inc/option_word_regs.svh
// Register offsets, field positions and reset values of the option block
`ifndef OPTION_WORD_REGS_SVH
`define OPTION_WORD_REGS_SVH
`define OPT_ADDR_WORD0 4'h0
`define OPT_ADDR_WORD1 4'h4
`define OPT_ADDR_STATUS 4'h8
`define OPT_BIT_TYPE 12
`define OPT_BIT_WDT_N 11
`define OPT_BIT_CYCLE 10
`define OPT_BIT_SECURE_N 9
`define OPT_BIT_FREQ 8
`define OPT_BIT_RESERVED 7
`define OPT_BIT_POWER 6
`define OPT_WORD0_ERASED 13'h1FFF
`define OPT_WORD1_ERASED 13'h1FFF
`define OPT_DIV_TWO_LAST 2'h1
`define OPT_DIV_FOUR_LAST 2'h3
`endif

//--- inc/option_word_pkg.sv
// Types shared by the option word decoder
package option_word_pkg;
   typedef logic [12:0] opt_word_t;
   typedef enum logic [1:0] {ST_RESET, ST_LOAD, ST_RUN} load_state_t;
endpackage : option_word_pkg

//--- design/option_word_config_decode.sv
// Option word storage, programmer access and decoded configuration
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "option_word_regs.svh"
module option_word_config_decode
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic por_n_in,
   input wire logic program_mode_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic rc_osc_mode_out,
   output logic high_xtal_mode_out,
   output logic low_xtal_mode_out,
   output logic watchdog_enable_out,
   output logic cycle_four_clk_out,
   output logic code_protect_out,
   output logic osc_power_high_out,
   output logic timer_tick_out,
   output logic config_valid_out
);

   // Stored option words, kept through ordinary resets
   option_word_pkg::opt_word_t word0_ff;
   option_word_pkg::opt_word_t word1_ff;
   option_word_pkg::opt_word_t nxt_word0;
   option_word_pkg::opt_word_t nxt_word1;
   option_word_pkg::load_state_t state_ff;
   option_word_pkg::load_state_t nxt_state;
   logic prog_meta_ff;
   logic prog_sync_ff;
   logic waitreq_ff;
   logic [31:0] readdata_ff;
   logic [31:0] nxt_readdata;
   logic rc_ff;
   logic hxt_ff;
   logic lxt_ff;
   logic wdt_ff;
   logic four_ff;
   logic protect_ff;
   logic power_ff;
   logic conflict_ff;
   logic valid_ff;
   logic tick_ff;
   logic [1:0] div_cnt_ff;
   logic [1:0] nxt_div_cnt;
   logic [1:0] div_last;

   // Bus decode
   wire req = avs_read_in | avs_write_in;
   wire accept = req & waitreq_ff;
   wire hit_word0 = avs_address_in == `OPT_ADDR_WORD0;
   wire hit_word1 = avs_address_in == `OPT_ADDR_WORD1;
   wire hit_status = avs_address_in == `OPT_ADDR_STATUS;
   wire commit_wr = avs_write_in & ~waitreq_ff;
   // Word access only for the programmer, never in normal operation
   wire word_open = prog_sync_ff;
   wire secure_on = ~word0_ff[`OPT_BIT_SECURE_N];
   wire word_readable = word_open & ~secure_on;
   wire wr_word0 = commit_wr & hit_word0 & word_open;
   wire wr_word1 = commit_wr & hit_word1 & word_open;

   // Byte lane merge of a write into a 13-bit word
   wire [12:0] lane_mask = {{5{avs_byteenable_in[1]}},
                            {8{avs_byteenable_in[0]}}};
   wire [12:0] wr_bits = avs_writedata_in[12:0];
   wire [12:0] merge0 = (word0_ff & ~lane_mask) | (wr_bits & lane_mask);
   wire [12:0] merge1 = (word1_ff & ~lane_mask) | (wr_bits & lane_mask);

   // Next stored words; reserved bit pinned high
   always_comb
   begin
      nxt_word0 = word0_ff;
      nxt_word1 = word1_ff;
      if (wr_word0)
      begin
         nxt_word0 = merge0;
      end
      if (wr_word1)
      begin
         nxt_word1 = merge1;
      end
      nxt_word0[`OPT_BIT_RESERVED] = 1'b1;
   end

   // Read data mux, registered at the answer
   wire [31:0] word0_rd = word_readable ? {19'h0, word0_ff} : 32'h0;
   wire [31:0] word1_rd = word_readable ? {19'h0, word1_ff} : 32'h0;
   wire [31:0] status_rd = {28'h0, conflict_ff, secure_on, valid_ff,
                            prog_sync_ff};
   assign nxt_readdata = ~(accept & avs_read_in) ? readdata_ff :
                         hit_word0 ? word0_rd :
                         hit_word1 ? word1_rd :
                         hit_status ? status_rd : 32'h0;

   // Decode of the stored first word
   wire type_xtal = word0_ff[`OPT_BIT_TYPE];
   wire freq_high = word0_ff[`OPT_BIT_FREQ];
   wire power_high = word0_ff[`OPT_BIT_POWER];
   wire dec_rc = ~type_xtal;
   wire dec_hxt = type_xtal & freq_high;
   wire dec_lxt = type_xtal & ~freq_high;
   // Crystal low with high power is undefined; flagged, kept as low
   wire dec_conflict = dec_lxt & power_high;
   wire dec_wdt = ~word0_ff[`OPT_BIT_WDT_N];
   wire dec_four = word0_ff[`OPT_BIT_CYCLE];

   // Load sequence after reset release
   assign nxt_state = (state_ff == option_word_pkg::ST_RESET) ?
                      option_word_pkg::ST_LOAD :
                      option_word_pkg::ST_RUN;
   wire load = state_ff == option_word_pkg::ST_LOAD;
   wire run = state_ff == option_word_pkg::ST_RUN;

   // Timer clock divider, by two or by four
   assign div_last = four_ff ? `OPT_DIV_FOUR_LAST : `OPT_DIV_TWO_LAST;
   wire div_wrap = div_cnt_ff == div_last;
   assign nxt_div_cnt = (~run | div_wrap) ? 2'h0 : div_cnt_ff + 2'h1;
   wire nxt_tick = run & div_wrap;

   // Storage on power-on reset only
   always_ff @(posedge clock_in or negedge por_n_in)
   begin
      if (!por_n_in)
      begin
         word0_ff <= `OPT_WORD0_ERASED;
         word1_ff <= `OPT_WORD1_ERASED;
      end
      else
      begin
         word0_ff <= nxt_word0;
         word1_ff <= nxt_word1;
      end
   end

   // Program mode pin synchroniser
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         prog_meta_ff <= 1'b0;
         prog_sync_ff <= 1'b0;
      end
      else
      begin
         prog_meta_ff <= program_mode_in;
         prog_sync_ff <= prog_meta_ff;
      end
   end

   // Bus slave answer, one wait cycle per access
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         waitreq_ff <= 1'b1;
         readdata_ff <= 32'h0;
      end
      else
      begin
         waitreq_ff <= ~accept;
         readdata_ff <= nxt_readdata;
      end
   end

   // Load state and divider
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_ff <= option_word_pkg::ST_RESET;
         div_cnt_ff <= 2'h0;
         tick_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         div_cnt_ff <= nxt_div_cnt;
         tick_ff <= nxt_tick;
      end
   end

   // Decoded settings, captured once and then held
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rc_ff <= 1'b1;
         hxt_ff <= 1'b0;
         lxt_ff <= 1'b0;
         wdt_ff <= 1'b0;
         four_ff <= 1'b0;
         protect_ff <= 1'b1;
         power_ff <= 1'b0;
         conflict_ff <= 1'b0;
         valid_ff <= 1'b0;
      end
      else if (load)
      begin
         rc_ff <= dec_rc;
         hxt_ff <= dec_hxt;
         lxt_ff <= dec_lxt;
         wdt_ff <= dec_wdt;
         four_ff <= dec_four;
         protect_ff <= secure_on;
         power_ff <= power_high;
         conflict_ff <= dec_conflict;
         valid_ff <= 1'b1;
      end
   end

   // Outputs straight from flops
   assign avs_readdata_out = readdata_ff;
   assign avs_waitrequest_out = waitreq_ff;
   assign rc_osc_mode_out = rc_ff;
   assign high_xtal_mode_out = hxt_ff;
   assign low_xtal_mode_out = lxt_ff;
   assign watchdog_enable_out = wdt_ff;
   assign cycle_four_clk_out = four_ff;
   assign code_protect_out = protect_ff;
   assign osc_power_high_out = power_ff;
   assign timer_tick_out = tick_ff;
   assign config_valid_out = valid_ff;

   // Bus answer timing
   a_wait_one_cycle: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (req && avs_waitrequest_out) |=> !avs_waitrequest_out)
      else $error("access not answered after one wait cycle");

   a_wait_release: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      !avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");

   // Words closed outside program mode
   a_word_closed: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (accept && avs_read_in && !prog_sync_ff && (hit_word0 || hit_word1))
      |=> avs_readdata_out == 32'h0)
      else $error("option word readable in normal operation");

   a_word_unchanged: assert property (@(posedge clock_in)
      disable iff (!rst_n_in || !por_n_in)
      (!prog_sync_ff && !$past(prog_sync_ff)) |=> $stable(word1_ff))
      else $error("option word changed outside program mode");

   a_reserved_high: assert property (@(posedge clock_in)
      disable iff (!por_n_in)
      ##1 word0_ff[`OPT_BIT_RESERVED])
      else $error("reserved option bit not one");

   // Decode at load
   a_mode_decode: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      load |=> (rc_osc_mode_out == !$past(word0_ff[`OPT_BIT_TYPE]))
      && (high_xtal_mode_out == ($past(word0_ff[`OPT_BIT_TYPE])
      && $past(word0_ff[`OPT_BIT_FREQ]))))
      else $error("oscillator mode decode wrong");

   a_mode_onehot: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      config_valid_out |-> $onehot({rc_osc_mode_out, high_xtal_mode_out,
      low_xtal_mode_out}))
      else $error("oscillator modes not exclusive");

   a_wdt_secure: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      load |=> (watchdog_enable_out == !$past(word0_ff[`OPT_BIT_WDT_N]))
      && (code_protect_out == !$past(word0_ff[`OPT_BIT_SECURE_N])))
      else $error("watchdog or security decode wrong");

   a_power_cycle: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      load |=> (osc_power_high_out == $past(word0_ff[`OPT_BIT_POWER]))
      && (cycle_four_clk_out == $past(word0_ff[`OPT_BIT_CYCLE])))
      else $error("power or cycle decode wrong");

   a_settings_hold: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (run && $past(run)) |-> $stable({rc_osc_mode_out, watchdog_enable_out,
      cycle_four_clk_out, code_protect_out, osc_power_high_out}))
      else $error("decoded settings moved during operation");

   // Timer clock spacing
   a_tick_by_four: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (timer_tick_out && cycle_four_clk_out)
      |=> !timer_tick_out [*3] ##1 timer_tick_out)
      else $error("timer clock not divided by four");

   a_tick_by_two: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (timer_tick_out && !cycle_four_clk_out)
      |=> !timer_tick_out ##1 timer_tick_out)
      else $error("timer clock not divided by two");

   a_valid_soon: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (state_ff == option_word_pkg::ST_RESET) |-> ##2 config_valid_out)
      else $error("settings not latched after reset");

endmodule : option_word_config_decode

//--- tb/option_programmer.sv
// Programmer model: drives the register bus and the program pin
`timescale 1ns/1ps
module option_programmer
(
   input wire logic clock_in,
   input wire logic [31:0] rdata_in,
   input wire logic wait_in,
   output logic prog_out,
   output logic [3:0] addr_out,
   output logic rd_out,
   output logic wr_out,
   output logic [31:0] wdata_out
);
   // Idle bus and pin at time zero
   initial
   begin
      prog_out = 1'b0;
      addr_out = 4'h0;
      rd_out = 1'b0;
      wr_out = 1'b0;
      wdata_out = 32'h0;
   end
   // Attach or detach, then wait out the pin synchroniser
   task automatic set_mode(input logic m);
      prog_out <= m;
      repeat (3) @(posedge clock_in);
   endtask : set_mode
   // One access, held until waitrequest is seen low or 20 cycles pass
   task automatic access(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic ok);
      ok = 1'b0;
      q = 32'h0;
      addr_out <= a;
      wr_out <= w;
      rd_out <= !w;
      wdata_out <= d;
      for (int n = 0; n < 20 && !ok; n++)
      begin
         @(negedge clock_in);
         ok = (wait_in === 1'b0);
         q = rdata_in;
         @(posedge clock_in);
      end
      rd_out <= 1'b0;
      wr_out <= 1'b0;
      wdata_out <= ~d; // Released lines lose old data
      @(posedge clock_in);
   endtask : access
   // Option word as a careful programmer writes it
   task automatic put_option(input logic [12:0] w, output logic ok);
      logic [31:0] q;
      access(1'b1, 4'h0, {19'h0, w[12:9], w[8] & w[12], 1'b1, w[6:0]},
         q, ok);
   endtask : put_option
endmodule : option_programmer

//--- tb/option_word_config_decode_tb_top.sv
// Self-checking bench for the option word decoder
`timescale 1ns/1ps
module option_word_config_decode_tb_top;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic por_n_in = 1'b0;
   logic prog, rd, wr, wreq, valid, tick;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic [6:0] cfg;
   int n_errors = 0;
   int samples_checked = 0;
   option_word_config_decode DUT
   (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
      .program_mode_in(prog), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq), .rc_osc_mode_out(cfg[6]),
      .high_xtal_mode_out(cfg[5]), .low_xtal_mode_out(cfg[4]),
      .watchdog_enable_out(cfg[3]), .cycle_four_clk_out(cfg[2]),
      .code_protect_out(cfg[1]), .osc_power_high_out(cfg[0]),
      .timer_tick_out(tick), .config_valid_out(valid)
   );
   option_programmer prog_m
   (
      .clock_in(clock_in), .rdata_in(rdata), .wait_in(wreq),
      .prog_out(prog), .addr_out(addr), .rd_out(rd), .wr_out(wr),
      .wdata_out(wdata)
   );
   // 50 MHz clock
   always #10 clock_in = ~clock_in;
   // Verdict and end of run
   task automatic summarize();
      if (n_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   // Compare one value
   task automatic check(input string s, input logic [31:0] e,
      input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask : check
   // Bus access; a lost answer ends the run
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      logic ok;
      prog_m.access(w, a, d, q, ok);
      if (!ok)
      begin
         n_errors++;
         summarize();
      end
   endtask : bus
   // Expected settings of a stored word
   function automatic logic [6:0] dec(input logic [12:0] w);
      return {!w[12], w[12] & w[8], w[12] & !w[8], !w[11], w[10], !w[9],
         w[6]};
   endfunction : dec
   // Reset pulse, then settings and timer tick rate
   task automatic restart(input logic [12:0] w);
      int t;
      t = 0;
      rst_n_in <= 1'b0;
      @(negedge clock_in);
      check("reset_cfg", 32'h42, {24'h0, valid, cfg});
      @(posedge clock_in);
      rst_n_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      check("decode", {24'h0, 1'b1, dec(w)}, {24'h0, valid, cfg});
      repeat (4) @(posedge clock_in);
      repeat (24)
      begin
         @(negedge clock_in);
         if (tick === 1'b1)
            t++;
      end
      check("ticks", w[10] ? 32'h6 : 32'hC, t);
      @(posedge clock_in);
   endtask : restart
   // Main sequence
   initial
   begin : main
      logic [31:0] q, s;
      logic ok;
      logic [12:0] tab [3] = '{13'h1F40, 13'h0D00, 13'h0000};
      repeat (2) @(posedge clock_in);
      por_n_in <= 1'b1;
      restart(13'h1FFF);
      bus(1'b1, 4'h0, 32'h0, q);
      bus(1'b0, 4'h0, 32'h0, q);
      check("locked_read", 32'h0, q);
      bus(1'b0, 4'h8, 32'h0, q);
      check("status", 32'h2, q);
      prog_m.set_mode(1'b1);
      bus(1'b1, 4'h4, 32'h1ABC, q);
      bus(1'b0, 4'h4, 32'h0, q);
      check("word1", 32'h1ABC, q);
      bus(1'b1, 4'hC, 32'hFFFF, q);
      bus(1'b0, 4'hC, 32'h0, q);
      check("unmapped", 32'h0, q);
      bus(1'b1, 4'h0, 32'h123F, q);
      bus(1'b0, 4'h0, 32'h0, q);
      check("reserved", 32'h12BF, q);
      @(negedge clock_in);
      check("held", {25'h0, dec(13'h1FFF)}, {25'h0, cfg});
      @(posedge clock_in);
      restart(13'h12BF);
      foreach (tab[i])
      begin
         prog_m.put_option(tab[i], ok);
         check("put_ok", 32'h1, {31'h0, ok});
         s = {19'h0, tab[i][12:9], tab[i][8] & tab[i][12], 1'b1,
            tab[i][6:0]};
         restart(s[12:0]);
         bus(1'b0, 4'h0, 32'h0, q);
         check("word0", tab[i][9] ? s : 32'h0, q);
      end
      summarize();
   end
endmodule : option_word_config_decode_tb_top
